// >>> design/adcc_top.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire adcc_apb_req_t APB_REQ_I,
  output adcc_apb_rsp_t APB_RSP_O,
  input wire logic CRYSTAL_CLK_I,
  input wire logic ADC_DONE_I,
  input wire logic [9:0] ADC_RESULT_I,
  output adcc_core_ctl_t ADC_CTL_O,
  output logic IRQ_O
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic setup;
  logic acc;
  logic wr_fire;
  logic rd_fire;
  logic sel_status;
  logic sel_hi;
  logic sel_lo;
  logic sel_clk;
  logic mapped;
  logic start_req;
  logic hold;

  // the slave is zero wait state; writes act on byte lane 0 only
  assign setup = APB_REQ_I.psel & ~APB_REQ_I.penable;
  assign acc = APB_REQ_I.psel & APB_REQ_I.penable;
  assign wr_fire = acc & APB_REQ_I.pwrite & APB_REQ_I.pstrb[0];
  assign rd_fire = acc & ~APB_REQ_I.pwrite;
  assign sel_status = (APB_REQ_I.paddr == ADCC_ADDR_STATUS);
  assign sel_hi = (APB_REQ_I.paddr == ADCC_ADDR_RES_HIGH);
  assign sel_lo = (APB_REQ_I.paddr == ADCC_ADDR_RES_LOW);
  assign sel_clk = (APB_REQ_I.paddr == ADCC_ADDR_CLOCK);
  assign mapped = sel_status | sel_hi | sel_lo | sel_clk;
  assign start_req = wr_fire & sel_status;
  // result commits wait while a result read is on the bus, so the value
  // latched at setup and the lock taken at access always agree
  assign hold = APB_REQ_I.psel & ~APB_REQ_I.pwrite & (sel_hi | sel_lo);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic irq_en_r;
  logic cont_r;
  logic [4:0] chan_r;
  logic [2:0] presc_r;
  logic src_r;
  adcc_fmt_t fmt_r;

  // done flag write position is ignored since it is read only
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_en_r <= 1'b0;
      cont_r <= 1'b0;
      chan_r <= ADCC_CHAN_RESET;
    end else if (start_req) begin
      irq_en_r <= APB_REQ_I.pwdata[ADCC_IRQ_EN_BIT];
      cont_r <= APB_REQ_I.pwdata[ADCC_CONT_BIT];
      chan_r <= APB_REQ_I.pwdata[ADCC_CHAN_LSB +: 5];
    end
  end

  // clock configuration; low two bits are reserved
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      presc_r <= ADCC_PRESC_RESET;
      src_r <= 1'b0;
      fmt_r <= ADCC_FMT_RESET;
    end else if (wr_fire & sel_clk) begin
      presc_r <= APB_REQ_I.pwdata[ADCC_PRESC_LSB +: 3];
      src_r <= APB_REQ_I.pwdata[ADCC_SRC_BIT];
      fmt_r <= adcc_fmt_t'(APB_REQ_I.pwdata[ADCC_FMT_LSB +: 2]);
    end
  end

  // ---------------------------------------------------------------
  // input clock selection and prescaler
  // ---------------------------------------------------------------
  logic xs1_r;
  logic xs2_r;
  logic xs3_r;
  logic src_tick;
  logic [3:0] div_max;
  logic [3:0] div_cnt_r;
  logic tick_r;

  // crystal clock is asynchronous: two flops, then an edge detector on
  // the second; limits the crystal to below half the bus rate
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end else begin
      xs1_r <= CRYSTAL_CLK_I;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end

  assign src_tick = src_r ? 1'b1 : (xs2_r & ~xs3_r);

  // divide ratio from the prescaler code
  always_comb begin
    case (presc_r)
      3'h0: div_max = 4'h0;
      3'h1: div_max = 4'h1;
      3'h2: div_max = 4'h3;
      3'h3: div_max = 4'h7;
      default: div_max = 4'hf;
    endcase
  end

  // free running so the first converter cycle after a start is a
  // fractional one, which gives the 15 to 16 cycle span
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      div_cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else if (src_tick && div_cnt_r >= div_max) begin
      div_cnt_r <= 4'h0;
      tick_r <= 1'b1;
    end else begin
      if (src_tick) begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
      tick_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  adcc_state_t state_r;
  logic [4:0] cnt_r;
  logic start_r;
  logic conv_end;

  // the core reports done once it has seen the full tick count
  assign conv_end = (state_r == ADCC_CONV) & ADC_DONE_I & (cnt_r == ADCC_CONV_TICKS)
                    & ~start_req;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state_r <= ADCC_IDLE;
      cnt_r <= 5'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (start_req) begin
        cnt_r <= 5'h0;
        if (APB_REQ_I.pwdata[ADCC_CHAN_LSB +: 5] == ADCC_CH_POWER_OFF) begin
          state_r <= ADCC_IDLE;
        end else begin
          state_r <= ADCC_CONV;
          start_r <= 1'b1;
        end
      end else begin
        case (state_r)
          ADCC_IDLE: begin
            state_r <= ADCC_IDLE;
          end
          ADCC_CONV: begin
            if (tick_r && cnt_r != ADCC_CONV_TICKS) begin
              cnt_r <= cnt_r + 5'h1;
            end
            if (conv_end) begin
              cnt_r <= 5'h0;
              if (cont_r) begin
                start_r <= 1'b1;
              end else begin
                state_r <= ADCC_IDLE;
              end
            end
          end
          default: begin
            state_r <= ADCC_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // result capture and interlock
  // ---------------------------------------------------------------
  logic [9:0] stg_r;
  logic stg_vld_r;
  logic commit;
  logic interlocked;
  logic lock_r;
  logic [9:0] raw_r;

  // staging keeps a result that ends while a result read is pending
  always_ff @(posedge CLK_I) begin
    if (SRST_I || start_req) begin
      stg_vld_r <= 1'b0;
      stg_r <= 10'h000;
    end else if (conv_end) begin
      stg_vld_r <= 1'b1;
      stg_r <= ADC_RESULT_I;
    end else if (commit) begin
      stg_vld_r <= 1'b0;
    end
  end

  assign commit = stg_vld_r & ~hold & ~start_req;
  assign interlocked = (fmt_r != ADCC_FMT_TRUNC8);

  // in interlocked formats a high read freezes low until low is read
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      lock_r <= 1'b0;
    end else if (rd_fire & sel_lo) begin
      lock_r <= 1'b0;
    end else if (rd_fire & sel_hi & interlocked) begin
      lock_r <= 1'b1;
    end
  end

  // locked results are dropped, not queued
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      raw_r <= 10'h000;
    end else if (commit & ~(lock_r & interlocked)) begin
      raw_r <= stg_r;
    end
  end

  // ---------------------------------------------------------------
  // done flag and interrupt request
  // ---------------------------------------------------------------
  logic done_r;
  logic irq_r;
  logic data_rd;

  assign data_rd = rd_fire & (sel_hi | sel_lo);

  // set wins over a clear in the same cycle
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (commit & ~irq_en_r) | (done_r & ~data_rd);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (commit & irq_en_r) | (irq_r & ~(data_rd | start_req));
    end
  end

  assign IRQ_O = irq_r;

  // ---------------------------------------------------------------
  // read data formatting
  // ---------------------------------------------------------------
  logic [7:0] hi_val;
  logic [7:0] lo_val;
  logic [7:0] rd_val;

  always_comb begin
    case (fmt_r)
      ADCC_FMT_TRUNC8: begin
        hi_val = 8'h00;
        lo_val = raw_r[9:2];
      end
      ADCC_FMT_LEFT: begin
        hi_val = raw_r[9:2];
        lo_val = {raw_r[1:0], 6'h00};
      end
      ADCC_FMT_LEFT_SIGNED: begin
        hi_val = {~raw_r[9], raw_r[8:2]};
        lo_val = {raw_r[1:0], 6'h00};
      end
      default: begin
        hi_val = {6'h00, raw_r[9:8]};
        lo_val = raw_r[7:0];
      end
    endcase
  end

  // done flag reads zero whenever interrupts are enabled
  always_comb begin
    if (sel_status) begin
      rd_val = {done_r & ~irq_en_r, irq_en_r, cont_r, chan_r};
    end else if (sel_hi) begin
      rd_val = hi_val;
    end else if (sel_lo) begin
      rd_val = lo_val;
    end else if (sel_clk) begin
      rd_val = {presc_r, src_r, fmt_r, 2'h0};
    end else begin
      rd_val = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // bus response
  // ---------------------------------------------------------------
  logic [31:0] prdata_r;

  // read data is latched in the setup cycle and held through access
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup & ~APB_REQ_I.pwrite) begin
      prdata_r <= {24'h00_0000, rd_val};
    end
  end

  assign APB_RSP_O.pready = acc;
  assign APB_RSP_O.prdata = prdata_r;
  assign APB_RSP_O.pslverr = acc & ~mapped;

  // ---------------------------------------------------------------
  // core control outputs
  // ---------------------------------------------------------------
  logic [ADCC_EXT_CH-1:0] ext_sel_r;
  logic pd_r;
  logic ref_hi_r;
  logic ref_lo_r;

  // unused and reserved codes select nothing; the result is undefined
  genvar g;
  generate
    for (g = 0; g < ADCC_EXT_CH; g = g + 1) begin : g_ext
      always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
          ext_sel_r[g] <= 1'b0;
        end else begin
          ext_sel_r[g] <= (chan_r == 5'(g));
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pd_r <= 1'b1;
      ref_hi_r <= 1'b0;
      ref_lo_r <= 1'b0;
    end else begin
      pd_r <= (chan_r == ADCC_CH_POWER_OFF);
      ref_hi_r <= (chan_r == ADCC_CH_REF_HIGH);
      ref_lo_r <= (chan_r == ADCC_CH_REF_LOW);
    end
  end

  assign ADC_CTL_O = {start_r, tick_r, pd_r, ext_sel_r, ref_hi_r, ref_lo_r};

endmodule : adcc_top

// >>> pkg/adcc_pkg.sv
//
// Function
// - a status/control write aborts any conversion and starts anew with new settings; channel code all ones goes idle instead
// - interrupts off: done flag sets per conversion, clears on result read or reset
// - interrupts on: done flag never sets and always reads zero
// - interrupts on: request per conversion, cleared by result read or control write
// - continuous bit repeats conversions; clear gives one conversion; reset clears it
// - five-bit channel codes 0..9 pick the ten external analog inputs
// - channel code all ones powers the converter off
// - codes 11101 and 11110 route high and low reference to converter input
// - unused or reserved channel codes give an undefined result
// - left format: result-high holds the eight top result bits
// - left format: result-low holds two bottom bits, other bits zero
// - right format: result-high bits 1:0 carry result bits 9:8, rest zero
// - right format: result-low holds the eight bottom result bits
// - truncation format: result-low holds eight top bits, no read interlock
// - interlocked formats: high read freezes low until read, new results dropped
// - prescaler codes divide by 1, 2, 4, 8; top bit set divides by 16
// - format field: 00 trunc, 01 right, 10 left, 11 left signed; reset right
// - signed left format inverts the result's top bit
// - clock source bit: one bus clock, zero crystal clock; reset crystal
// - a conversion spans 16 to 17 prescaled clock cycles from its start; the logic counts 16 ticks, so it spans 15 to 16
package adcc_pkg;

  // ---------------------------------------------------------------
  // register map (index, byte address is four times index)
  // ---------------------------------------------------------------
  localparam int ADCC_ADDR_W = 12;
  localparam logic [7:0] ADCC_IDX_STATUS = 8'h40;
  localparam logic [7:0] ADCC_IDX_RES_HIGH = 8'h41;
  localparam logic [7:0] ADCC_IDX_RES_LOW = 8'h42;
  localparam logic [7:0] ADCC_IDX_CLOCK = 8'h43;
  localparam logic [ADCC_ADDR_W-1:0] ADCC_ADDR_STATUS = {2'h0, ADCC_IDX_STATUS, 2'h0};
  localparam logic [ADCC_ADDR_W-1:0] ADCC_ADDR_RES_HIGH = {2'h0, ADCC_IDX_RES_HIGH, 2'h0};
  localparam logic [ADCC_ADDR_W-1:0] ADCC_ADDR_RES_LOW = {2'h0, ADCC_IDX_RES_LOW, 2'h0};
  localparam logic [ADCC_ADDR_W-1:0] ADCC_ADDR_CLOCK = {2'h0, ADCC_IDX_CLOCK, 2'h0};

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ADCC_DONE_BIT = 7;
  localparam int ADCC_IRQ_EN_BIT = 6;
  localparam int ADCC_CONT_BIT = 5;
  localparam int ADCC_CHAN_LSB = 0;
  localparam int ADCC_PRESC_LSB = 5;
  localparam int ADCC_SRC_BIT = 4;
  localparam int ADCC_FMT_LSB = 2;
  localparam logic [4:0] ADCC_CHAN_RESET = 5'h1f;
  localparam logic [4:0] ADCC_CH_POWER_OFF = 5'h1f;
  localparam logic [4:0] ADCC_CH_REF_HIGH = 5'h1d;
  localparam logic [4:0] ADCC_CH_REF_LOW = 5'h1e;
  localparam int ADCC_EXT_CH = 10;
  localparam logic [2:0] ADCC_PRESC_RESET = 3'h0;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [4:0] ADCC_CONV_TICKS = 5'h10;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCC_FMT_TRUNC8 = 2'h0,
    ADCC_FMT_RIGHT = 2'h1,
    ADCC_FMT_LEFT = 2'h2,
    ADCC_FMT_LEFT_SIGNED = 2'h3
  } adcc_fmt_t;
  localparam adcc_fmt_t ADCC_FMT_RESET = ADCC_FMT_RIGHT;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADCC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } adcc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } adcc_apb_rsp_t;

  typedef struct packed {
    logic start;
    logic tick;
    logic power_down;
    logic [ADCC_EXT_CH-1:0] ext_sel;
    logic ref_high;
    logic ref_low;
  } adcc_core_ctl_t;

endpackage : adcc_pkg

// >>> sim/adcc_monitor.sv
`timescale 1ns/1ps
module adcc_monitor
  import adcc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire adcc_apb_req_t APB_REQ_I,
  input wire adcc_apb_rsp_t APB_RSP_O,
  input wire adcc_core_ctl_t ADC_CTL_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  logic acc;
  logic irq_en_r;
  adcc_fmt_t fmt_r;
  assign acc = APB_REQ_I.psel && APB_REQ_I.penable;

  sequence s_wr_stat;
    acc && APB_REQ_I.pwrite && APB_REQ_I.pstrb[0] && APB_REQ_I.paddr == ADCC_ADDR_STATUS;
  endsequence
  sequence s_rd(logic [ADCC_ADDR_W-1:0] a);
    acc && !APB_REQ_I.pwrite && APB_REQ_I.paddr == a;
  endsequence

  // shadow enable and format, so read data can be judged without peeking inside
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_en_r <= 1'b0;
      fmt_r <= ADCC_FMT_RESET;
    end else if (acc && APB_REQ_I.pwrite && APB_REQ_I.pstrb[0]) begin
      if (APB_REQ_I.paddr == ADCC_ADDR_STATUS) irq_en_r <= APB_REQ_I.pwdata[6];
      if (APB_REQ_I.paddr == ADCC_ADDR_CLOCK) fmt_r <= adcc_fmt_t'(APB_REQ_I.pwdata[3:2]);
    end
  end

  start_on_write_a: assert property (
    s_wr_stat ##0 APB_REQ_I.pwdata[4:0] != 5'h1f |=> ADC_CTL_O.start)
    else $error("no start after status write");
  power_off_a: assert property (
    s_wr_stat ##0 APB_REQ_I.pwdata[4:0] == 5'h1f |=> !ADC_CTL_O.start ##1 ADC_CTL_O.power_down)
    else $error("power off code not honoured");
  ext_select_a: assert property (
    s_wr_stat ##0 APB_REQ_I.pwdata[4:0] < 5'h0a |=> ##1
    ADC_CTL_O.ext_sel == 10'h001 << $past(APB_REQ_I.pwdata[4:0], 2))
    else $error("wrong external input selected");
  ref_route_a: assert property (
    s_wr_stat ##0 APB_REQ_I.pwdata[4:0] == 5'h1d |=> ##1
    ADC_CTL_O.ref_high && !ADC_CTL_O.ref_low && ADC_CTL_O.ext_sel == 10'h000)
    else $error("high reference not routed");
  irq_gated_a: assert property ($rose(IRQ_O) |-> $past(irq_en_r))
    else $error("interrupt raised while disabled");
  done_hidden_a: assert property (
    s_rd(ADCC_ADDR_STATUS) ##0 irq_en_r |-> !APB_RSP_O.prdata[7])
    else $error("done flag visible with interrupts on");
  right_high_a: assert property (
    s_rd(ADCC_ADDR_RES_HIGH) ##0 fmt_r == ADCC_FMT_RIGHT |-> APB_RSP_O.prdata[7:2] == 6'h00)
    else $error("right format high bits not zero");
  left_low_a: assert property (
    s_rd(ADCC_ADDR_RES_LOW) ##0 fmt_r[1] |-> APB_RSP_O.prdata[5:0] == 6'h00)
    else $error("left format low bits not zero");
  trunc_high_a: assert property (
    s_rd(ADCC_ADDR_RES_HIGH) ##0 fmt_r == ADCC_FMT_TRUNC8 |-> APB_RSP_O.prdata == 32'h0)
    else $error("truncation format high not zero");
  unmapped_err_a: assert property (acc && APB_REQ_I.paddr[11:4] != 8'h10 |-> APB_RSP_O.pslverr)
    else $error("unmapped access without error");
endmodule : adcc_monitor

bind adcc_top adcc_monitor u_adcc_monitor (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .APB_REQ_I(APB_REQ_I), .APB_RSP_O(APB_RSP_O), .ADC_CTL_O(ADC_CTL_O), .IRQ_O(IRQ_O));

// >>> sim/adcc_core_model.sv
`timescale 1ns/1ps
module adcc_core_model
  import adcc_pkg::*;
(
  input wire logic clk_i,
  input wire adcc_core_ctl_t ctl_i,
  input wire logic [9:0] value_i,
  output logic done_o,
  output logic [9:0] result_o
);
  logic [4:0] ticks_r = 5'h1f;
  logic done_r = 1'b0;

  // count converter ticks since the last start; saturate so idle never re-fires
  always_ff @(posedge clk_i) begin
    if (ctl_i.start) ticks_r <= 5'h00;
    else if (ctl_i.tick && ticks_r != 5'h1f) ticks_r <= ticks_r + 5'h01;
  end

  // done pulses once, right after the sixteenth tick
  always_ff @(posedge clk_i) begin
    done_r <= !ctl_i.start && ctl_i.tick && ticks_r == 5'h0f;
  end

  // result only holds while done; otherwise inverted so a stale capture shows
  assign done_o = done_r;
  assign result_o = done_r ? value_i : ~value_i;
endmodule : adcc_core_model

// >>> sim/adc_control_result_regs_bench.sv
`timescale 1ns/1ps
module adc_control_result_regs_bench
  import adcc_pkg::*;
;
  logic clk;
  logic srst;
  logic xtal;
  adcc_apb_req_t req;
  adcc_apb_rsp_t rsp;
  adcc_core_ctl_t ctl;
  logic irq;
  logic done;
  logic [9:0] res;
  logic [9:0] value_r;
  logic [7:0] rd_q;
  logic rd_e;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  adcc_top u_adcc_top (.CLK_I(clk), .SRST_I(srst), .APB_REQ_I(req), .APB_RSP_O(rsp),
    .CRYSTAL_CLK_I(xtal), .ADC_DONE_I(done), .ADC_RESULT_I(res), .ADC_CTL_O(ctl), .IRQ_O(irq));
  adcc_core_model u_adcc_core_model (.clk_i(clk), .ctl_i(ctl), .value_i(value_r),
    .done_o(done), .result_o(res));

  // ---------------------------------------------------------------
  // clock, crystal (eight cycles a period) and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    xtal <= cycles[2];
    if (cycles == 30000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one transfer; zero-wait slave, but pready is waited for anyway
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, {24'h0, d}, 4'hf};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd_q = rsp.prdata[7:0];
    rd_e = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADCC_ADDR_STATUS, 8'h00);
      n++;
    end while (rd_q[7] !== 1'b1 && n < 300);
    chk(rd_q[7], 1'b1);
  endtask : wait_done

  task automatic next_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ctl.tick !== 1'b1 && n < 400);
  endtask : next_tick

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, ADCC_ADDR_STATUS, 8'h00);
    chk({ctl.power_down, rd_q}, 9'h11f);
    apb(1'b0, ADCC_ADDR_CLOCK, 8'h00);
    chk(rd_q, 8'h04);
    apb(1'b0, 12'h200, 8'h00);
    chk({rd_e, rd_q}, 9'h100);
    $display("reset test done");
  endtask : t_reset

  // each status write aborts the last; done bit always written as zero
  task automatic t_channels();
    logic [12:0] exp;
    for (int c = 0; c < 32; c++) begin
      if (c < 10 || c > 28) begin
        apb(1'b1, ADCC_ADDR_STATUS, 8'(c));
        repeat (3) @(posedge clk);
        #1;
        exp = {c == 31, c == 29, c == 30, (c < 10) ? 10'h001 << c : 10'h000};
        chk({ctl.power_down, ctl.ref_high, ctl.ref_low, ctl.ext_sel}, exp);
      end
    end
    $display("channel test done");
  endtask : t_channels

  task automatic t_formats();
    logic [9:0] v;
    logic [15:0] got;
    logic [15:0] exp;
    v = 10'h2a5;
    value_r <= v;
    apb(1'b1, ADCC_ADDR_STATUS, 8'h00);
    wait_done();
    apb(1'b0, ADCC_ADDR_RES_LOW, 8'h00);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, ADCC_ADDR_CLOCK, {4'h1, 2'(f), 2'h0});
      apb(1'b1, ADCC_ADDR_STATUS, 8'h00);
      wait_done();
      apb(1'b0, ADCC_ADDR_RES_HIGH, 8'h00);
      got[15:8] = rd_q;
      apb(1'b0, ADCC_ADDR_RES_LOW, 8'h00);
      got[7:0] = rd_q;
      case (f)
        0: exp = {8'h00, v[9:2]};
        1: exp = {6'h00, v};
        2: exp = {v, 6'h00};
        default: exp = {~v[9], v[8:0], 6'h00};
      endcase
      chk(got, exp);
      apb(1'b0, ADCC_ADDR_STATUS, 8'h00);
      chk({irq, rd_q[7]}, 2'h0);
    end
    $display("format test done");
  endtask : t_formats

  task automatic t_irq();
    int n;
    apb(1'b1, ADCC_ADDR_CLOCK, 8'h94);
    apb(1'b1, ADCC_ADDR_STATUS, 8'h41);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 400);
    chk(n > 240 && n <= 290, 1'b1);
    apb(1'b0, ADCC_ADDR_STATUS, 8'h00);
    chk(rd_q, 8'h41);
    apb(1'b0, ADCC_ADDR_RES_LOW, 8'h00);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_presc();
    int n;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ADCC_ADDR_CLOCK, (i < 5) ? {3'(i), 5'h14} : 8'h04);
      apb(1'b1, ADCC_ADDR_STATUS, 8'h00);
      next_tick(n);
      next_tick(n);
      chk(n, (i < 5) ? (1 << i) : 8);
    end
    $display("prescaler test done");
  endtask : t_presc

  // high read freezes low; results finishing meanwhile must be dropped
  task automatic t_lock();
    apb(1'b1, ADCC_ADDR_CLOCK, 8'h14);
    value_r <= 10'h155;
    apb(1'b1, ADCC_ADDR_STATUS, 8'h22);
    wait_done();
    apb(1'b0, ADCC_ADDR_RES_HIGH, 8'h00);
    chk(rd_q, 8'h01);
    value_r <= 10'h0ea;
    wait_done();
    apb(1'b0, ADCC_ADDR_RES_LOW, 8'h00);
    chk(rd_q, 8'h55);
    wait_done();
    apb(1'b0, ADCC_ADDR_RES_HIGH, 8'h00);
    chk(rd_q, 8'h00);
    apb(1'b0, ADCC_ADDR_RES_LOW, 8'h00);
    chk(rd_q, 8'hea);
    apb(1'b1, ADCC_ADDR_STATUS, 8'h1f);
    $display("interlock test done");
  endtask : t_lock

  initial begin
    srst = 1'b1;
    req = '0;
    value_r = 10'h000;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_channels();
    t_formats();
    t_irq();
    t_presc();
    t_lock();
    conclude();
  end
endmodule : adc_control_result_regs_bench
